// ===== logic/dcsw_pkg.sv
// Package: bit positions, setting codes and states of the command/status word block
package dcsw_pkg;
  localparam int unsigned WORD_W       = 16;
  // Native command word bit positions
  localparam int unsigned CMD_DC_BRAKE = 2;
  localparam int unsigned CMD_COAST    = 3;
  localparam int unsigned CMD_QSTOP    = 4;
  localparam int unsigned CMD_HOLD     = 5;
  localparam int unsigned CMD_START    = 6;
  localparam int unsigned CMD_RESET    = 7;
  localparam int unsigned CMD_JOG      = 8;
  localparam int unsigned CMD_RAMP     = 9;
  localparam int unsigned CMD_VALID    = 10;
  localparam int unsigned CMD_RELAY    = 11;
  localparam int unsigned CMD_DOUT     = 12;
  localparam int unsigned CMD_SETUP_LO = 13;
  localparam int unsigned CMD_SETUP_HI = 14;
  localparam int unsigned CMD_REVERSE  = 15;
  // Fieldbus command word: the three enable bits
  localparam int unsigned FB_ON1       = 0;
  localparam int unsigned FB_ON2       = 1;
  localparam int unsigned FB_ON3       = 2;
  // Status word bit positions
  localparam int unsigned ST_READY     = 0;
  localparam int unsigned ST_DRV_READY = 1;
  localparam int unsigned ST_CAN_START = 2;
  localparam int unsigned ST_TRIP      = 3;
  localparam int unsigned ST_UNUSED4   = 4;
  localparam int unsigned ST_UNUSED5   = 5;
  localparam int unsigned ST_TRIP_LOCK = 6;
  localparam int unsigned ST_WARNING   = 7;
  localparam int unsigned ST_AT_SPEED  = 8;
  localparam int unsigned ST_SERIAL_OK = 9;
  localparam int unsigned ST_FREQ_OK   = 10;
  localparam int unsigned ST_RUNNING   = 11;
  localparam int unsigned ST_UNUSED12  = 12;
  localparam int unsigned ST_VOLT_WARN = 13;
  localparam int unsigned ST_CURR_LIM  = 14;
  localparam int unsigned ST_THERM     = 15;
  // Reset values of the held command fields
  localparam logic [WORD_W-1:0] CMD_WORD_RESET = 16'h0000;
  localparam logic [1:0]        SETUP_RESET    = 2'h0;
  // Reversing source setting codes
  typedef enum logic [1:0] {
    DCSW_REV_DIGITAL = 2'b00,
    DCSW_REV_SERIAL  = 2'b01,
    DCSW_REV_OR      = 2'b10,
    DCSW_REV_AND     = 2'b11
  } dcsw_rev_src_t;
  // Start gating setting codes
  typedef enum logic [1:0] {
    DCSW_START_INPUT  = 2'b00,
    DCSW_START_SERIAL = 2'b01,
    DCSW_START_OR     = 2'b10,
    DCSW_START_AND    = 2'b11
  } dcsw_start_src_t;
  // Telegram profile select
  typedef enum logic {
    DCSW_PROF_FIELDBUS = 1'b0,
    DCSW_PROF_NATIVE   = 1'b1
  } dcsw_profile_t;
  // Run command state
  typedef enum logic [1:0] {
    DCSW_STOPPED  = 2'b00,
    DCSW_RUNNING  = 2'b01,
    DCSW_RAMPDOWN = 2'b10,
    DCSW_COASTING = 2'b11
  } dcsw_run_t;
endpackage

// ===== logic/dcsw_gate.sv
// Source gating of one command bit against its digital input counterpart
`timescale 1ns/10ps
module dcsw_gate (
  input  wire logic [1:0] mode,
  input  wire logic       bus_bit,
  input  wire logic       pin_bit,
  output logic            gated
);
  // Mode codes share the reversing/start encoding: pin, bus, or, and
  always_comb begin
    unique case (mode)
      2'b00: gated = pin_bit;
      2'b01: gated = bus_bit;
      2'b10: gated = bus_bit | pin_bit;
      2'b11: gated = bus_bit & pin_bit;
    endcase
  end
endmodule

// ===== logic/dcsw_core.sv
// Command word interpreter and status word builder for the drive control path
`timescale 1ns/10ps
// Notes on behaviour
// - Command bit 05 low freezes output frequency; only speed-up/down inputs move it.
// - While frozen, bit 06 and start inputs cannot stop; bits 03, 02, pins can.
// - Bit 06 low ramps down on selected ramp; high permits start, gated per setting.
// - Trip clears only on a rising edge of command bit 07.
// - Bit 08 high selects jog frequency instead of the normal reference.
// - Bit 09 picks ramp set 1 or ramp set 2.
// - Command word with bit 10 low is discarded entirely.
// - Bit 11 drives relay 01 only when its source selects the command bit.
// - Bit 12 drives terminal 46 output only when its source selects the command bit.
// - Bits 14:13 select setup 1 to 4, only in multi-setup operation.
// - Bit 15 reverses only with serial, logic-or or logic-and reversing source.
// - Status bit 00 shows drive ready for operation.
// - Status bit 02 low when motor coasts, high when start possible.
// - Status bit 03 shows a trip awaiting reset.
// - Status bit 06 shows trip lock, cleared only by power cycle or backup supply.
// - Status bit 07 shows any warning present.
// - Status bit 08 shows actual speed equal to reference.
// - Status bit 09 low when local stop key or local mode; serial then ignored.
// - Status bit 10 high within frequency limits, low at low or high limit.
// - Status bit 11 high on start signal or nonzero output frequency.
// - Status bits 13, 14, 15 flag voltage, current ceiling and thermal limits.
// - Fieldbus profile: any of bits 00..02 low ramps stop; all high permit start.
module dcsw_core (
  input  wire logic                          core_clk,
  input  wire logic                          rst_b,
  // Command word from the telegram layer
  input  wire logic [dcsw_pkg::WORD_W-1:0]   native_command_word,
  input  wire logic [dcsw_pkg::WORD_W-1:0]   fieldbus_command_word,
  input  wire logic                          cmd_word_strobe,
  input  wire logic                          profile_native,
  // Settings
  input  wire logic [1:0]                    start_source,
  input  wire logic [1:0]                    reverse_source,
  input  wire logic                          relay_src_is_cmd,
  input  wire logic                          dout_src_is_cmd,
  input  wire logic                          multi_setup_en,
  input  wire logic                          local_mode,
  // Digital inputs and local control (asynchronous pins)
  input  wire logic                          pin_start,
  input  wire logic                          pin_reverse,
  input  wire logic                          pin_dc_brake,
  input  wire logic                          pin_coast,
  input  wire logic                          pin_speed_up,
  input  wire logic                          pin_speed_down,
  input  wire logic                          local_stop_key,
  // Drive state from the motor control
  input  wire logic                          drive_ready,
  input  wire logic                          trip_event,
  input  wire logic                          trip_lock_event,
  input  wire logic                          power_restored,
  input  wire logic                          warning_any,
  input  wire logic                          speed_at_ref,
  input  wire logic                          freq_at_limit,
  input  wire logic                          freq_nonzero,
  input  wire logic                          dc_link_out_of_range,
  input  wire logic                          output_current_ceiling,
  input  wire logic                          temp_limit,
  // Commands to the motor control, relay and terminal outputs, and the status word
  output logic                               freq_hold,
  output logic                               hold_speed_up,
  output logic                               hold_speed_down,
  output logic                               run_enable,
  output logic                               ramp_stop,
  output logic                               coast_stop,
  output logic                               dc_brake,
  output logic                               quick_stop,
  output logic                               jog_select,
  output logic                               ramp_set2,
  output logic                               relay01_on,
  output logic                               dout46_on,
  output logic [1:0]                         setup_select,
  output logic                               reverse,
  output logic                               trip_reset_pulse,
  output logic [dcsw_pkg::WORD_W-1:0]        native_status_word
);

  // Two-flop synchronisers for all pin inputs
  localparam int unsigned NPIN = 7;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {local_stop_key, pin_speed_down, pin_speed_up, pin_coast,
                   pin_dc_brake, pin_reverse, pin_start};
      pin_sync <= pin_meta;
    end
  end

  logic s_start, s_rev, s_dcb, s_coast, s_up, s_down, s_lstop;
  assign {s_lstop, s_down, s_up, s_coast, s_dcb, s_rev, s_start} = pin_sync;

  // Serial commands only count when local control does not own the drive
  logic serial_ok;
  assign serial_ok = !s_lstop && !local_mode;

  logic accept;
  assign accept = cmd_word_strobe && serial_ok && profile_native
                  && native_command_word[dcsw_pkg::CMD_VALID];

  logic fb_accept;
  assign fb_accept = cmd_word_strobe && serial_ok && !profile_native
                     && fieldbus_command_word[dcsw_pkg::CMD_VALID];

  // Held command word; reset value keeps coast/stop bits low so nothing starts
  logic [dcsw_pkg::WORD_W-1:0] cmd;
  logic                        fb_on_all;
  logic                        prev_reset_bit;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cmd <= dcsw_pkg::CMD_WORD_RESET;
    end else if (accept) begin
      cmd <= native_command_word;
    end else if (fb_accept) begin
      // Fieldbus bits 03..15 shared with native meanings for the covered subset
      cmd <= {fieldbus_command_word[dcsw_pkg::WORD_W-1:dcsw_pkg::CMD_COAST],
              3'h7};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      fb_on_all <= 1'b0;
    end else if (fb_accept) begin
      fb_on_all <= fieldbus_command_word[dcsw_pkg::FB_ON1]
                   & fieldbus_command_word[dcsw_pkg::FB_ON2]
                   & fieldbus_command_word[dcsw_pkg::FB_ON3];
    end else if (accept) begin
      fb_on_all <= 1'b1;
    end
  end

  // Trip reset on 0->1 of bit 07 across accepted words only
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      prev_reset_bit   <= 1'b0;
      trip_reset_pulse <= 1'b0;
    end else begin
      trip_reset_pulse <= 1'b0;
      if (accept || fb_accept) begin
        prev_reset_bit <= native_command_word[dcsw_pkg::CMD_RESET] & profile_native
                        | fieldbus_command_word[dcsw_pkg::CMD_RESET] & !profile_native;
        trip_reset_pulse <= !prev_reset_bit
                          && (profile_native ? native_command_word[dcsw_pkg::CMD_RESET]
                                             : fieldbus_command_word[dcsw_pkg::CMD_RESET]);
      end
    end
  end

  // Trip and trip-lock flags; a new trip wins over a reset in the same cycle
  logic tripped;
  logic trip_locked;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tripped <= 1'b0;
    end else if (trip_event || trip_lock_event) begin
      tripped <= 1'b1;
    end else if (trip_reset_pulse && !trip_locked) begin
      tripped <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      trip_locked <= 1'b0;
    end else if (trip_lock_event) begin
      trip_locked <= 1'b1;
    end else if (power_restored) begin
      trip_locked <= 1'b0;
    end
  end

  // Start gating of bit 06 against start pin
  logic start_gated;
  dcsw_gate u_start_gate (
    .mode    (start_source),
    .bus_bit (cmd[dcsw_pkg::CMD_START]),
    .pin_bit (s_start),
    .gated   (start_gated)
  );

  logic rev_gated;
  dcsw_gate u_rev_gate (
    .mode    (reverse_source),
    .bus_bit (cmd[dcsw_pkg::CMD_REVERSE]),
    .pin_bit (s_rev),
    .gated   (rev_gated)
  );

  // Hard stops that act even while frozen
  logic hard_coast;
  logic hard_brake;
  assign hard_coast = !cmd[dcsw_pkg::CMD_COAST] || s_coast;
  assign hard_brake = !cmd[dcsw_pkg::CMD_DC_BRAKE] || s_dcb;

  logic hold;
  assign hold = !cmd[dcsw_pkg::CMD_HOLD];

  // Run state
  dcsw_pkg::dcsw_run_t run_q;
  dcsw_pkg::dcsw_run_t next_run;
  logic                start_ok;
  assign start_ok = start_gated && fb_on_all && !tripped;

  always_comb begin
    next_run = run_q;
    if (hard_coast) begin
      next_run = dcsw_pkg::DCSW_COASTING;
    end else if (hard_brake) begin
      next_run = dcsw_pkg::DCSW_STOPPED;
    end else begin
      unique case (run_q)
        dcsw_pkg::DCSW_STOPPED, dcsw_pkg::DCSW_COASTING: begin
          if (start_ok) next_run = dcsw_pkg::DCSW_RUNNING;
          else next_run = dcsw_pkg::DCSW_STOPPED;
        end
        dcsw_pkg::DCSW_RUNNING: begin
          // Frozen output cannot be stopped by bit 06 or start input
          if (!start_ok && !hold) next_run = dcsw_pkg::DCSW_RAMPDOWN;
        end
        dcsw_pkg::DCSW_RAMPDOWN: begin
          if (start_ok) next_run = dcsw_pkg::DCSW_RUNNING;
          else if (!freq_nonzero) next_run = dcsw_pkg::DCSW_STOPPED;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) run_q <= dcsw_pkg::DCSW_STOPPED;
    else run_q <= next_run;
  end

  // Registered command outputs
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      freq_hold       <= 1'b0;
      hold_speed_up   <= 1'b0;
      hold_speed_down <= 1'b0;
      run_enable      <= 1'b0;
      ramp_stop       <= 1'b0;
      coast_stop      <= 1'b1;
      dc_brake        <= 1'b0;
      quick_stop      <= 1'b0;
    end else begin
      freq_hold       <= hold && run_q == dcsw_pkg::DCSW_RUNNING;
      hold_speed_up   <= hold && s_up;
      hold_speed_down <= hold && s_down;
      run_enable      <= next_run == dcsw_pkg::DCSW_RUNNING;
      ramp_stop       <= next_run == dcsw_pkg::DCSW_RAMPDOWN;
      coast_stop      <= hard_coast;
      dc_brake        <= hard_brake && !hard_coast;
      quick_stop      <= !cmd[dcsw_pkg::CMD_QSTOP];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      jog_select   <= 1'b0;
      ramp_set2    <= 1'b0;
      relay01_on   <= 1'b0;
      dout46_on    <= 1'b0;
      setup_select <= dcsw_pkg::SETUP_RESET;
      reverse      <= 1'b0;
    end else begin
      jog_select <= profile_native && cmd[dcsw_pkg::CMD_JOG];
      ramp_set2  <= cmd[dcsw_pkg::CMD_RAMP];
      relay01_on <= profile_native && relay_src_is_cmd && cmd[dcsw_pkg::CMD_RELAY];
      dout46_on  <= profile_native && dout_src_is_cmd && cmd[dcsw_pkg::CMD_DOUT];
      if (multi_setup_en) begin
        setup_select <= cmd[dcsw_pkg::CMD_SETUP_HI:dcsw_pkg::CMD_SETUP_LO];
      end
      reverse <= rev_gated;
    end
  end

  // Status word
  logic running_flag;
  assign running_flag = start_gated || freq_nonzero;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      native_status_word <= '0;
    end else begin
      native_status_word                          <= '0;
      native_status_word[dcsw_pkg::ST_READY]      <= drive_ready;
      native_status_word[dcsw_pkg::ST_DRV_READY]  <= drive_ready && hard_coast;
      native_status_word[dcsw_pkg::ST_CAN_START]  <= !hard_coast && !tripped;
      native_status_word[dcsw_pkg::ST_TRIP]       <= tripped;
      native_status_word[dcsw_pkg::ST_TRIP_LOCK]  <= trip_locked;
      native_status_word[dcsw_pkg::ST_WARNING]    <= warning_any;
      native_status_word[dcsw_pkg::ST_AT_SPEED]   <= speed_at_ref;
      native_status_word[dcsw_pkg::ST_SERIAL_OK]  <= serial_ok;
      native_status_word[dcsw_pkg::ST_FREQ_OK]    <= !freq_at_limit;
      native_status_word[dcsw_pkg::ST_RUNNING]    <= running_flag;
      native_status_word[dcsw_pkg::ST_VOLT_WARN]  <= dc_link_out_of_range;
      native_status_word[dcsw_pkg::ST_CURR_LIM]   <= output_current_ceiling;
      native_status_word[dcsw_pkg::ST_THERM]      <= temp_limit;
    end
  end

endmodule

// ===== tb/dcsw_master.sv
// Bus master model: presents command words one telegram at a time
`timescale 1ns/10ps
module dcsw_master (
  input  wire logic        core_clk,
  output logic [15:0]      native_command_word,
  output logic [15:0]      fieldbus_command_word,
  output logic             cmd_word_strobe,
  output logic             profile_native
);
  logic [15:0] last_w;
  initial begin
    native_command_word = 16'h0000;
    fieldbus_command_word = 16'h0000;
    cmd_word_strobe = 1'h0;
    profile_native = 1'h1;
    last_w = 16'h0000;
  end
  // Unselected word carries junk so a wrong profile pick shows up
  task automatic send(input logic [15:0] w, input logic prof);
    @(posedge core_clk);
    cmd_word_strobe <= 1'h1;
    profile_native <= prof;
    native_command_word <= prof ? w : ~w;
    fieldbus_command_word <= prof ? ~w : w;
    last_w = w;
  endtask
  task automatic quiet();
    @(posedge core_clk);
    cmd_word_strobe <= 1'h0;
    native_command_word <= ~last_w;
    fieldbus_command_word <= last_w ^ 16'hA5A5;
  endtask
endmodule

// ===== tb/dcsw_checker.sv
// Checker: port properties of the command and status word interpreter
`timescale 1ns/10ps
module dcsw_checker (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic [15:0] native_command_word,
  input wire logic [15:0] fieldbus_command_word,
  input wire logic        cmd_word_strobe,
  input wire logic        profile_native,
  input wire logic        local_mode,
  input wire logic        local_stop_key,
  input wire logic        relay_src_is_cmd,
  input wire logic        trip_event,
  input wire logic        power_restored,
  input wire logic        warning_any,
  input wire logic        dc_link_out_of_range,
  input wire logic        output_current_ceiling,
  input wire logic        temp_limit,
  input wire logic        jog_select,
  input wire logic        ramp_set2,
  input wire logic        relay01_on,
  input wire logic        trip_reset_pulse,
  input wire logic [15:0] native_status_word
);
  logic [15:0] sel_w;
  logic [15:0] w1;
  logic [15:0] w2;
  logic        acc;
  logic        a1;
  logic        a2;
  logic        rise_q;
  logic        last7;
  logic        key_m;
  logic        key_s;
  assign sel_w = profile_native ? native_command_word : fieldbus_command_word;
  // Stop key seen through the same two-flop delay as the design
  assign acc = cmd_word_strobe & sel_w[10] & ~local_mode & ~key_s;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      a1 <= 1'h0;
      a2 <= 1'h0;
      rise_q <= 1'h0;
      last7 <= 1'h0;
      key_m <= 1'h0;
      key_s <= 1'h0;
    end else begin
      key_m <= local_stop_key;
      key_s <= key_m;
      a1 <= acc;
      a2 <= a1;
      rise_q <= acc & sel_w[7] & ~last7;
      if (acc) begin
        last7 <= sel_w[7];
      end
    end
  end
  always_ff @(posedge core_clk) begin
    w1 <= sel_w;
    w2 <= w1;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_taken;
    acc ##2 1'h1;
  endsequence
  sequence s_flags_steady;
    $stable({warning_any, dc_link_out_of_range, output_current_ceiling, temp_limit}) [*2];
  endsequence
  property p_jog_ramp;
    s_taken |-> {jog_select, ramp_set2} == {w2[8], w2[9]};
  endproperty
  property p_relay;
    s_taken |-> relay01_on == (w2[11] & relay_src_is_cmd);
  endproperty
  property p_discard;
    !a2 |-> $stable({jog_select, ramp_set2});
  endproperty
  property p_trip_pulse;
    trip_reset_pulse == rise_q;
  endproperty
  property p_trip_status;
    trip_event |-> ##[1:2] native_status_word[3];
  endproperty
  property p_lock_kept;
    native_status_word[6] && !power_restored && !$past(power_restored)
      |=> native_status_word[6];
  endproperty
  property p_flags;
    s_flags_steady |=> {native_status_word[15:13], native_status_word[7]} ==
      $past({temp_limit, output_current_ceiling, dc_link_out_of_range, warning_any});
  endproperty
  property p_local;
    local_mode [*2] |=> !native_status_word[9];
  endproperty
  property p_unused;
    native_status_word[12] == 1'h0 && native_status_word[5:4] == 2'h0;
  endproperty
  a_jog_ramp: assert property (p_jog_ramp) else $error("jog or ramp wrong");
  a_relay: assert property (p_relay) else $error("relay wrong");
  a_discard: assert property (p_discard) else $error("outputs moved");
  a_trip_pulse: assert property (p_trip_pulse) else $error("reset pulse wrong");
  a_trip_status: assert property (p_trip_status) else $error("trip not shown");
  a_lock_kept: assert property (p_lock_kept) else $error("lock lost");
  a_flags: assert property (p_flags) else $error("flag bits wrong");
  a_local: assert property (p_local) else $error("serial bit set");
  a_unused: assert property (p_unused) else $error("unused bit set");
endmodule
bind dcsw_core dcsw_checker dcsw_checker_i (.*);

// ===== tb/drive_control_status_word_tb.sv
// Testbench: telegram scenarios against the command and status word interpreter
`timescale 1ns/10ps
module drive_control_status_word_tb;
  logic        core_clk, rst_b, cmd_word_strobe, profile_native;
  logic [15:0] native_command_word, fieldbus_command_word, native_status_word;
  logic [1:0]  start_source, reverse_source, setup_select;
  logic        relay_src_is_cmd, dout_src_is_cmd, multi_setup_en, local_mode, pin_start;
  logic        pin_reverse, pin_dc_brake, pin_coast, pin_speed_up, pin_speed_down;
  logic        local_stop_key, drive_ready, trip_event, trip_lock_event, power_restored;
  logic        warning_any, speed_at_ref, freq_at_limit, freq_nonzero, dc_link_out_of_range;
  logic        output_current_ceiling, temp_limit, freq_hold, hold_speed_up, hold_speed_down;
  logic        run_enable, ramp_stop, coast_stop, dc_brake, quick_stop, jog_select;
  logic        ramp_set2, relay01_on, dout46_on, reverse, trip_reset_pulse;
  logic [3:0]  exp4;
  int          mismatches = 0;
  int          checked = 0;
  int          pulses = 0;
  int          p0;
  int          sel_bit[4] = '{8, 9, 11, 12};
  logic [15:0] st_exp[2] = '{16'h0A00, 16'hEF80};
  dcsw_core dcsw_core_i (.*);
  dcsw_master dcsw_master_i (.*);
  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end
  // Whole run takes a few hundred cycles; this allows about tenfold
  initial begin
    #60000;
    mismatches++;
    end_of_test();
  end
  always @(posedge core_clk) begin
    if (trip_reset_pulse === 1'h1) begin
      pulses <= pulses + 1;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic apply(input logic [15:0] w, input logic prof);
    dcsw_master_i.send(w, prof);
    dcsw_master_i.quiet();
    wait_cyc(2);
  endtask
  task automatic test_done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    rst_b = 1'h0;
    {start_source, reverse_source} = 4'h5;
    {relay_src_is_cmd, dout_src_is_cmd, multi_setup_en, drive_ready} = 4'hF;
    {local_mode, pin_start, pin_reverse, pin_dc_brake, pin_coast, pin_speed_up,
     pin_speed_down, local_stop_key, trip_event, trip_lock_event, power_restored,
     warning_any, speed_at_ref, freq_at_limit, dc_link_out_of_range,
     output_current_ceiling, temp_limit} = 17'h0;
    // Motor still turning, so a ramp stop stands until freq_nonzero falls
    freq_nonzero = 1'h1;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'h1;
    apply(16'h047F, 1'h1);
    check(16'({run_enable, quick_stop, coast_stop}), 16'h0004);
    check(16'(native_status_word[2:0]), 16'h0005);
    apply(16'h043F, 1'h1);
    check(16'({run_enable, ramp_stop}), 16'h0001);
    @(posedge core_clk);
    freq_nonzero <= 1'h0;
    wait_cyc(2);
    check(16'({run_enable, ramp_stop}), 16'h0000);
    @(posedge core_clk);
    freq_nonzero <= 1'h1;
    start_source <= 2'h0;
    apply(16'h047F, 1'h1);
    check(16'(run_enable), 16'h0000);
    @(posedge core_clk);
    start_source <= 2'h1;
    test_done("start");
    apply(16'h047F, 1'h1);
    apply(16'h045F, 1'h1);
    check(16'({freq_hold, run_enable}), 16'h0003);
    apply(16'h041F, 1'h1);
    check(16'({run_enable, ramp_stop}), 16'h0002);
    @(posedge core_clk);
    pin_speed_up <= 1'h1;
    wait_cyc(4);
    check(16'({hold_speed_up, hold_speed_down}), 16'h0002);
    @(posedge core_clk);
    {pin_speed_up, pin_speed_down} <= 2'h1;
    wait_cyc(4);
    check(16'({hold_speed_up, hold_speed_down}), 16'h0001);
    @(posedge core_clk);
    pin_speed_down <= 1'h0;
    apply(16'h041B, 1'h1);
    check(16'(dc_brake), 16'h0001);
    apply(16'h0417, 1'h1);
    check(16'(coast_stop), 16'h0001);
    test_done("freeze");
    for (int i = 0; i < 4; i++) begin
      apply(16'h047F | (16'h0001 << sel_bit[i]), 1'h1);
      exp4 = 4'h8 >> i;
      check(16'({jog_select, ramp_set2}), 16'(exp4[3:2]));
      check(16'({relay01_on, dout46_on}), 16'(exp4[1:0]));
    end
    @(posedge core_clk);
    {relay_src_is_cmd, dout_src_is_cmd} <= 2'h0;
    apply(16'h1C7F, 1'h1);
    check(16'({relay01_on, dout46_on}), 16'h0000);
    for (int s = 0; s < 4; s++) begin
      apply(16'h047F | (16'(s) << 13), 1'h1);
      check(16'(setup_select), 16'(s));
    end
    @(posedge core_clk);
    multi_setup_en <= 1'h0;
    apply(16'h047F, 1'h1);
    check(16'(setup_select), 16'h0003);
    for (int r = 0; r < 4; r++) begin
      @(posedge core_clk);
      reverse_source <= 2'(r);
      pin_reverse <= (r == 3);
      apply(16'h847F, 1'h1);
      check(16'(reverse), 16'(r != 0));
    end
    test_done("outputs");
    apply(16'h017F, 1'h1);
    check(16'(jog_select), 16'h0000);
    dcsw_master_i.send(16'h017F, 1'h1);
    apply(16'h067F, 1'h1);
    check(16'({jog_select, ramp_set2}), 16'h0001);
    @(posedge core_clk);
    local_mode <= 1'h1;
    wait_cyc(2);
    check(16'(native_status_word[9]), 16'h0000);
    apply(16'h057F, 1'h1);
    check(16'(jog_select), 16'h0000);
    @(posedge core_clk);
    local_mode <= 1'h0;
    local_stop_key <= 1'h1;
    wait_cyc(4);
    check(16'(native_status_word[9]), 16'h0000);
    @(posedge core_clk);
    local_stop_key <= 1'h0;
    wait_cyc(4);
    check(16'(native_status_word[9]), 16'h0001);
    test_done("discard");
    for (int t = 0; t < 2; t++) begin
      @(posedge core_clk);
      trip_event <= 1'h1;
      @(posedge core_clk);
      trip_event <= 1'h0;
      wait_cyc(2);
      check(16'(native_status_word[3]), 16'h0001);
      p0 = pulses;
      apply(16'h04FF, 1'h1);
      wait_cyc(2);
      check(16'(native_status_word[3]), 16'(t));
      check(16'(pulses - p0), 16'(1 - t));
    end
    @(posedge core_clk);
    trip_lock_event <= 1'h1;
    @(posedge core_clk);
    trip_lock_event <= 1'h0;
    apply(16'h047F, 1'h1);
    apply(16'h04FF, 1'h1);
    wait_cyc(2);
    check(16'({native_status_word[6], native_status_word[3]}), 16'h0003);
    @(posedge core_clk);
    power_restored <= 1'h1;
    @(posedge core_clk);
    power_restored <= 1'h0;
    wait_cyc(3);
    check(16'(native_status_word[6]), 16'h0000);
    apply(16'h047F, 1'h1);
    apply(16'h04FF, 1'h1);
    check(16'(native_status_word[3]), 16'h0000);
    test_done("trip");
    for (int k = 1; k >= 0; k--) begin
      @(posedge core_clk);
      {warning_any, speed_at_ref, dc_link_out_of_range, output_current_ceiling,
       temp_limit} <= {5{k[0]}};
      {freq_at_limit, freq_nonzero} <= {~k[0], 1'h1};
      wait_cyc(3);
      check(native_status_word & 16'h01B0, st_exp[k] & 16'h01B0);
      check(native_status_word & 16'hFE00, st_exp[k] & 16'hFE00);
    end
    @(posedge core_clk);
    drive_ready <= 1'h0;
    wait_cyc(3);
    check(16'(native_status_word[0]), 16'h0000);
    @(posedge core_clk);
    drive_ready <= 1'h1;
    test_done("status");
    apply(16'h047F, 1'h0);
    check(16'(run_enable), 16'h0001);
    for (int b = 0; b < 3; b++) begin
      apply(16'h047F & ~(16'h0001 << b), 1'h0);
      check(16'({run_enable, ramp_stop}), 16'h0001);
      apply(16'h047F, 1'h0);
    end
    test_done("fieldbus");
    end_of_test();
  end
endmodule
